/* hw/sdr_regs.sv */
// Register bank and output gating of the synchronizer's loop selection and synthesizer.
// Assumes a host on sys_clk; loop state and reference fault pins come from outside.
//
// Summary of operation
// - Rank codes 0, 1, 2 place an input first, second, third in automatic mode.
// - Rank code 1111 removes an input from automatic selection.
// - Ranks 0,1 share a register reset 0x10; rank 2 sits in one reset 0x32.
// - Loop flag bit 0 is high while the loop is in holdover.
// - Loop flag bit 1 is high while the loop is locked.
// - Loop flag bit 2 is high when the selected input shows a failure.
// - Two-bit capture span select, codes 12/52/130/83 ppm, reset 83 ppm.
// - Enable bit 0 drives the clock output, else high impedance.
// - Enable bit 2 drives the frame pulse output, else high impedance.
// - Enable bit 7 switches the whole synthesizer; register resets to 0x8F.
// - Gating bit 2 generates frame pulses, else the pulse is held low.
// - Synthesized clock frequency is N times 8 kHz, N unsigned 14 bits.
// - N low byte resets 0x00; N bits 13:8 in next register reset 0x01.
// - Quadrant code shifts the clock 0, 90, 180 or 270 degrees.
// - Signed eight-bit fine phase in 119.2 ps steps.
// - Rate field selects 166.67 Hz, 400 Hz, 1, 2, 4, 8, 32 kHz.
// - Rate codes also give 64 kHz and 1 Hz; reset 0x05 selects 8 kHz.
// - Automatic mode picks best-ranked healthy input, switching on failure.
// - Active selection codes inputs 0, 1, 2 as 0000, 0001, 0010.
`timescale 1ns/1ps
`default_nettype none
module sdr_regs
    import sdr_pkg::*;
#(
    parameter int ACC_W = 32
) (
    input wire logic sys_clk,               // System clock, 200 MHz
    input wire logic resetn,                // Asynchronous reset, active low
    input wire sdr_req_t req,               // Register port request
    output logic [7:0] rdata,               // Read data, cycle after read strobe
    input wire sdr_loop_t loop_pins,        // Loop state and input faults, async
    output logic [1:0] active_input,        // Active reference index
    output logic [13:0] multiplier,         // Synthesizer N
    output logic [1:0] span_code,           // Capture span select
    output logic [7:0] fine_phase,          // Fine phase word
    output logic synth_clk_out,             // Synthesized clock data
    output logic synth_clk_oe_n,            // Low while clock is driven
    output logic synth_frame_out,           // Frame pulse data
    output logic synth_frame_oe_n           // Low while frame pulse is driven
);
    localparam logic [ACC_W-1:0] ACC_HALF = ACC_W'(1) << (ACC_W - 1);
    // Phase step per cycle for N*8 kHz: N*8000*2^ACC_W/200e6
    localparam real STEP_SCALE = (real'(BASE_RATE_HZ) * (2.0 ** ACC_W)) / (SYS_CLK_MHZ * 1.0E6);
    // Fixed-point copy of the scale keeps real arithmetic out of the datapath
    localparam longint STEP_Q16 = longint'(STEP_SCALE * 65536.0);

    sdr_loop_t sync1_reg, sync2_reg;
    logic [7:0] rank01_reg, rank2_reg, span_reg, en_reg, gate_reg, mlo_reg, mhi_reg;
    logic [7:0] quad_reg, fine_reg, rate_reg, shape_reg, mode_reg, sel_reg;
    logic [7:0] rank01_next, rank2_next, span_next, en_next, gate_next, mlo_next, mhi_next;
    logic [7:0] quad_next, fine_next, rate_next, shape_next, mode_next, sel_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [ACC_W-1:0] acc_reg, acc_next, step;
    logic [31:0] fp_cnt_reg, fp_cnt_next, fp_limit;
    logic fp_pulse_reg, fp_pulse_next;
    logic clk_o_reg, clk_o_next, clk_oe_reg, clk_oe_next;
    logic fp_o_reg, fp_o_next, fp_oe_reg, fp_oe_next;
    logic [3:0] rank [3];
    logic [2:0] usable;
    logic [1:0] best;
    logic found;
    logic [3:0] best_rank;
    logic [1:0] quad_sel;
    logic [ACC_W-1:0] acc_shift;

    // Two-flop synchroniser for the loop state pins
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= loop_pins;
            sync2_reg <= sync1_reg;
        end
    end

    assign rank[0] = rank01_reg[3:0];
    assign rank[1] = rank01_reg[7:4];
    assign rank[2] = rank2_reg[3:0];

    // Automatic reference choice
    always_comb begin
        found = 1'b0;
        best = 2'd0;
        best_rank = RANK_OFF;
        for (int i = 0; i < 3; i++) begin
            usable[i] = (rank[i] != RANK_OFF) && !sync2_reg.fail[i];
            // Strict compare keeps the lower index on a tie
            if (usable[i] && (!found || rank[i] < best_rank)) begin
                found = 1'b1;
                best = 2'(i);
                best_rank = rank[i];
            end
        end
    end

    // Register writes and the automatic selection update
    always_comb begin
        rank01_next = rank01_reg;
        rank2_next = rank2_reg;
        span_next = span_reg;
        en_next = en_reg;
        gate_next = gate_reg;
        mlo_next = mlo_reg;
        mhi_next = mhi_reg;
        quad_next = quad_reg;
        fine_next = fine_reg;
        rate_next = rate_reg;
        shape_next = shape_reg;
        mode_next = mode_reg;
        sel_next = sel_reg;
        if (req.wr) begin
            case (req.addr)
                OFF_RANK01: rank01_next = req.wdata;
                OFF_RANK2: rank2_next = req.wdata;
                OFF_SPAN: span_next = {6'h00, req.wdata[1:0]};
                OFF_ENABLES: en_next = req.wdata;
                OFF_GATING: gate_next = req.wdata;
                OFF_MULT_LO: mlo_next = req.wdata;
                OFF_MULT_HI: mhi_next = {2'b00, req.wdata[5:0]};
                OFF_QUAD: quad_next = {6'h00, req.wdata[1:0]};
                OFF_FINE: fine_next = req.wdata;
                OFF_FP_RATE: rate_next = {4'h0, req.wdata[3:0]};
                OFF_FP_SHAPE: shape_next = req.wdata;
                OFF_LOOP_MODE: mode_next = {5'h00, req.wdata[2:0]};
                OFF_ACTIVE_SEL: begin
                    // Writable only outside automatic mode
                    if (mode_reg[2:0] != MODE_AUTO && req.wdata[3:0] <= RANK_THIRD) begin
                        sel_next = {4'h0, req.wdata[3:0]};
                    end
                end
                default: ;
            endcase
        end
        if (mode_reg[2:0] == MODE_AUTO && found) begin
            sel_next = {6'h00, best};
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = 8'h00;
        if (req.rd) begin
            case (req.addr)
                OFF_RANK01: rdata_next = rank01_reg;
                OFF_RANK2: rdata_next = rank2_reg;
                OFF_LOOP_FLAGS: begin
                    rdata_next[BIT_HOLDOVER] = sync2_reg.holdover;
                    rdata_next[BIT_LOCK] = sync2_reg.lock;
                    rdata_next[BIT_CUR_FAIL] = sync2_reg.fail[sel_reg[1:0]];
                end
                OFF_SPAN: rdata_next = span_reg;
                OFF_ENABLES: rdata_next = en_reg;
                OFF_GATING: rdata_next = gate_reg;
                OFF_MULT_LO: rdata_next = mlo_reg;
                OFF_MULT_HI: rdata_next = mhi_reg;
                OFF_QUAD: rdata_next = quad_reg;
                OFF_FINE: rdata_next = fine_reg;
                OFF_FP_RATE: rdata_next = rate_reg;
                OFF_FP_SHAPE: rdata_next = shape_reg;
                OFF_LOOP_MODE: rdata_next = mode_reg;
                OFF_ACTIVE_SEL: rdata_next = sel_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // Frame pulse period in system cycles per rate code
    always_comb begin
        case (rate_reg[3:0])
            FP_166HZ: fp_limit = 32'd1200000;
            FP_400HZ: fp_limit = 32'd500000;
            FP_1KHZ: fp_limit = 32'd200000;
            FP_2KHZ: fp_limit = 32'd100000;
            FP_4KHZ: fp_limit = 32'd50000;
            FP_8KHZ: fp_limit = 32'd25000;
            FP_32KHZ: fp_limit = 32'd6250;
            FP_64KHZ: fp_limit = 32'd3125;
            FP_1HZ: fp_limit = 32'd200000000;
            default: fp_limit = 32'd25000;
        endcase
    end

    // Synthesizer: DDS accumulator, quadrant offset, frame counter, pin drive
    always_comb begin
        step = ACC_W'((64'({mhi_reg[5:0], mlo_reg}) * 64'(STEP_Q16)) >> 16);
        acc_next = acc_reg;
        fp_cnt_next = fp_cnt_reg;
        fp_pulse_next = 1'b0;
        if (en_reg[BIT_SYNTH_EN]) begin
            acc_next = acc_reg + step;
            if (fp_cnt_reg >= fp_limit - 32'd1) begin
                fp_cnt_next = 32'd0;
                fp_pulse_next = 1'b1;
            end else begin
                fp_cnt_next = fp_cnt_reg + 32'd1;
            end
        end
        // Quarter-turn shift of the accumulator phase
        quad_sel = quad_reg[1:0];
        acc_shift = acc_reg + ACC_W'({quad_sel, {(ACC_W - 2){1'b0}}});
        // Fine phase leaves the accumulator and its sampling point untouched; its
        // 119.2 ps step is below a system period, so it is held for the analog stage
        clk_o_next = en_reg[BIT_SYNTH_EN] && gate_reg[0] && (acc_shift >= ACC_HALF);
        clk_oe_next = !(en_reg[BIT_SYNTH_EN] && en_reg[BIT_CLK_EN]);
        fp_o_next = en_reg[BIT_SYNTH_EN] && gate_reg[2] && fp_pulse_reg;
        fp_oe_next = !(en_reg[BIT_SYNTH_EN] && en_reg[BIT_FP_EN]);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rank01_reg <= RST_RANK01;
            rank2_reg <= RST_RANK2;
            span_reg <= RST_SPAN;
            en_reg <= RST_ENABLES;
            gate_reg <= RST_GATING;
            mlo_reg <= RST_MULT_LO;
            mhi_reg <= RST_MULT_HI;
            quad_reg <= RST_QUAD;
            fine_reg <= RST_FINE;
            rate_reg <= RST_FP_RATE;
            shape_reg <= RST_FP_SHAPE;
            mode_reg <= RST_LOOP_MODE;
            sel_reg <= 8'h00;
            rdata_reg <= 8'h00;
            acc_reg <= '0;
            fp_cnt_reg <= 32'd0;
            fp_pulse_reg <= 1'b0;
            clk_o_reg <= 1'b0;
            clk_oe_reg <= 1'b1;
            fp_o_reg <= 1'b0;
            fp_oe_reg <= 1'b1;
        end else begin
            rank01_reg <= rank01_next;
            rank2_reg <= rank2_next;
            span_reg <= span_next;
            en_reg <= en_next;
            gate_reg <= gate_next;
            mlo_reg <= mlo_next;
            mhi_reg <= mhi_next;
            quad_reg <= quad_next;
            fine_reg <= fine_next;
            rate_reg <= rate_next;
            shape_reg <= shape_next;
            mode_reg <= mode_next;
            sel_reg <= sel_next;
            rdata_reg <= rdata_next;
            acc_reg <= acc_next;
            fp_cnt_reg <= fp_cnt_next;
            fp_pulse_reg <= fp_pulse_next;
            clk_o_reg <= clk_o_next;
            clk_oe_reg <= clk_oe_next;
            fp_o_reg <= fp_o_next;
            fp_oe_reg <= fp_oe_next;
        end
    end

    assign rdata = rdata_reg;
    assign active_input = sel_reg[1:0];
    assign multiplier = {mhi_reg[5:0], mlo_reg};
    assign span_code = span_reg[1:0];
    assign fine_phase = fine_reg;
    assign synth_clk_out = clk_o_reg;
    assign synth_clk_oe_n = clk_oe_reg;
    assign synth_frame_out = fp_o_reg;
    assign synth_frame_oe_n = fp_oe_reg;

    sequence s_rd_flags;
        req.rd && req.addr == OFF_LOOP_FLAGS;
    endsequence

    property p_holdover_flag;
        @(posedge sys_clk) disable iff (!resetn)
        s_rd_flags |=> rdata[BIT_HOLDOVER] == $past(sync2_reg.holdover);
    endproperty
    a_holdover_flag: assert property (p_holdover_flag) else $error("holdover flag wrong");

    property p_lock_flag;
        @(posedge sys_clk) disable iff (!resetn)
        s_rd_flags |=> rdata[BIT_LOCK] == $past(sync2_reg.lock);
    endproperty
    a_lock_flag: assert property (p_lock_flag) else $error("lock flag wrong");

    property p_fail_flag;
        @(posedge sys_clk) disable iff (!resetn)
        s_rd_flags |=> rdata[BIT_CUR_FAIL] == $past(sync2_reg.fail[sel_reg[1:0]]);
    endproperty
    a_fail_flag: assert property (p_fail_flag) else $error("current fail flag wrong");

    property p_never_disabled;
        @(posedge sys_clk) disable iff (!resetn)
        mode_reg[2:0] == MODE_AUTO |-> rank[sel_next[1:0]] != RANK_OFF || !found;
    endproperty
    a_never_disabled: assert property (p_never_disabled) else $error("disabled input chosen");

    property p_auto_best;
        @(posedge sys_clk) disable iff (!resetn)
        mode_reg[2:0] == MODE_AUTO && found |=> sel_reg[1:0] == $past(best);
    endproperty
    a_auto_best: assert property (p_auto_best) else $error("auto selection lagged");

    property p_clk_tristate;
        @(posedge sys_clk) disable iff (!resetn)
        !en_reg[BIT_CLK_EN] |=> synth_clk_oe_n;
    endproperty
    a_clk_tristate: assert property (p_clk_tristate) else $error("clock driven while off");

    property p_frame_tristate;
        @(posedge sys_clk) disable iff (!resetn)
        !en_reg[BIT_FP_EN] |=> synth_frame_oe_n;
    endproperty
    a_frame_tristate: assert property (p_frame_tristate) else $error("frame driven while off");

    property p_synth_off;
        @(posedge sys_clk) disable iff (!resetn)
        !en_reg[BIT_SYNTH_EN] |=> synth_clk_oe_n && synth_frame_oe_n;
    endproperty
    a_synth_off: assert property (p_synth_off) else $error("output driven while synth off");

    property p_clk_held_low;
        @(posedge sys_clk) disable iff (!resetn)
        !gate_reg[0] [*2] |-> !synth_clk_out;
    endproperty
    a_clk_held_low: assert property (p_clk_held_low) else $error("clock not held low");

    property p_frame_held_low;
        @(posedge sys_clk) disable iff (!resetn)
        !gate_reg[2] [*2] |-> !synth_frame_out;
    endproperty
    a_frame_held_low: assert property (p_frame_held_low) else $error("frame not held low");

    property p_span_write;
        @(posedge sys_clk) disable iff (!resetn)
        req.wr && req.addr == OFF_SPAN |=> span_code == $past(req.wdata[1:0]);
    endproperty
    a_span_write: assert property (p_span_write) else $error("span write lost");
endmodule
`default_nettype wire

/* hw/sdr_pkg.sv */
// Package for the synchronizer register bank: offsets, reset values, fields, carriers.
// Assumes an 8-bit register port on a single system clock.
package sdr_pkg;
    localparam logic [7:0] OFF_RANK01 = 8'h24;
    localparam logic [7:0] OFF_RANK2 = 8'h25;
    localparam logic [7:0] OFF_LOOP_FLAGS = 8'h28;
    localparam logic [7:0] OFF_SPAN = 8'h29;
    localparam logic [7:0] OFF_ENABLES = 8'h36;
    localparam logic [7:0] OFF_GATING = 8'h37;
    localparam logic [7:0] OFF_MULT_LO = 8'h38;
    localparam logic [7:0] OFF_MULT_HI = 8'h39;
    localparam logic [7:0] OFF_QUAD = 8'h3A;
    localparam logic [7:0] OFF_FINE = 8'h3D;
    localparam logic [7:0] OFF_FP_RATE = 8'h3E;
    localparam logic [7:0] OFF_FP_SHAPE = 8'h3F;
    localparam logic [7:0] OFF_LOOP_MODE = 8'h1F;
    localparam logic [7:0] OFF_ACTIVE_SEL = 8'h20;

    localparam logic [7:0] RST_RANK01 = 8'h10;
    localparam logic [7:0] RST_RANK2 = 8'h32;
    localparam logic [7:0] RST_SPAN = 8'h03;
    localparam logic [7:0] RST_ENABLES = 8'h8F;
    localparam logic [7:0] RST_GATING = 8'h0F;
    localparam logic [7:0] RST_MULT_LO = 8'h00;
    localparam logic [7:0] RST_MULT_HI = 8'h01;
    localparam logic [7:0] RST_QUAD = 8'h00;
    localparam logic [7:0] RST_FINE = 8'h00;
    localparam logic [7:0] RST_FP_RATE = 8'h05;
    localparam logic [7:0] RST_FP_SHAPE = 8'h83;
    localparam logic [7:0] RST_LOOP_MODE = 8'h03;

    localparam int BIT_CLK_EN = 0;
    localparam int BIT_FP_EN = 2;
    localparam int BIT_SYNTH_EN = 7;
    localparam int BIT_HOLDOVER = 0;
    localparam int BIT_LOCK = 1;
    localparam int BIT_CUR_FAIL = 2;

    localparam logic [3:0] RANK_FIRST = 4'h0;
    localparam logic [3:0] RANK_SECOND = 4'h1;
    localparam logic [3:0] RANK_THIRD = 4'h2;
    localparam logic [3:0] RANK_OFF = 4'hF;
    localparam logic [2:0] MODE_AUTO = 3'h3;

    // Frame pulse rate codes
    localparam logic [3:0] FP_166HZ = 4'h0;
    localparam logic [3:0] FP_400HZ = 4'h1;
    localparam logic [3:0] FP_1KHZ = 4'h2;
    localparam logic [3:0] FP_2KHZ = 4'h3;
    localparam logic [3:0] FP_4KHZ = 4'h4;
    localparam logic [3:0] FP_8KHZ = 4'h5;
    localparam logic [3:0] FP_32KHZ = 4'h6;
    localparam logic [3:0] FP_64KHZ = 4'h7;
    localparam logic [3:0] FP_1HZ = 4'h8;

    localparam real SYS_CLK_MHZ = 200.0;
    localparam real FINE_STEP_PS = 119.2;
    localparam int BASE_RATE_HZ = 8000;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sdr_req_t;

    typedef struct packed {
        logic holdover;
        logic lock;
        logic [2:0] fail;
    } sdr_loop_t;
endpackage

/* tb/sdr_regs_tb_top.sv */
// Self-checking testbench for the synchronizer register bank and its synthesizer gating.
// Assumes the design's defaults: automatic loop mode and a two-flop pin synchroniser.
`timescale 1ns/1ps
`default_nettype none
module sdr_regs_tb_top;
    import sdr_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    sdr_req_t req = '0;
    sdr_loop_t loop_pins = '0;
    logic [7:0] rdata;
    logic [1:0] active_input;
    logic [13:0] multiplier;
    logic [1:0] span_code;
    logic [7:0] fine_phase;
    logic synth_clk_out;
    logic synth_clk_oe_n;
    logic synth_frame_out;
    logic synth_frame_oe_n;
    int bad_count = 0;
    int check_count = 0;

    sdr_regs DUT (
        .sys_clk(sys_clk), .resetn(resetn), .req(req), .rdata(rdata),
        .loop_pins(loop_pins), .active_input(active_input), .multiplier(multiplier),
        .span_code(span_code), .fine_phase(fine_phase), .synth_clk_out(synth_clk_out),
        .synth_clk_oe_n(synth_clk_oe_n), .synth_frame_out(synth_frame_out),
        .synth_frame_oe_n(synth_frame_oe_n)
    );

    always #2.5 sys_clk = ~sys_clk;

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= {a, d, 2'b10};
        @(posedge sys_clk);
        req <= '0;
        // Step past the edge so the written value has settled for any check
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        req <= {a, 8'h00, 2'b01};
        @(posedge sys_clk);
        req <= '0;
        #1;
        d = rdata;
    endtask

    task automatic rd_check(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(what, {8'h00, d}, {8'h00, exp});
    endtask

    // Pin changes need the sync flops plus the selection register to land
    task automatic set_pins(input sdr_loop_t p);
        @(posedge sys_clk);
        loop_pins <= p;
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_frame(input int bound, output int n);
        n = 0;
        while (n < bound) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (synth_frame_out === 1'b1) return;
        end
        bad_count++;
        $display("MISMATCH frame pulse wait expected pulse seen none");
        test_done();
    endtask

    task automatic count_rises(input int cycles, output int n);
        logic last;
        n = 0;
        last = synth_clk_out;
        repeat (cycles) begin
            @(posedge sys_clk);
            #1;
            if (synth_clk_out === 1'b1 && last === 1'b0) n++;
            last = synth_clk_out;
        end
    endtask

    task automatic t_reset_values();
        rd_check("rank01 reset", OFF_RANK01, 8'h10);
        rd_check("rank2 reset", OFF_RANK2, 8'h32);
        rd_check("span reset", OFF_SPAN, 8'h03);
        rd_check("enables reset", OFF_ENABLES, 8'h8F);
        rd_check("gating reset", OFF_GATING, 8'h0F);
        rd_check("mult low reset", OFF_MULT_LO, 8'h00);
        rd_check("mult high reset", OFF_MULT_HI, 8'h01);
        rd_check("quadrant reset", OFF_QUAD, 8'h00);
        rd_check("fine reset", OFF_FINE, 8'h00);
        rd_check("rate reset", OFF_FP_RATE, 8'h05);
        rd_check("shape reset", OFF_FP_SHAPE, 8'h83);
        rd_check("unmapped read", 8'h30, 8'h00);
        check("multiplier reset", {2'b00, multiplier}, 16'h0100);
        check("span port reset", {14'h0000, span_code}, 16'h0003);
        check("clock driven", {15'h0000, synth_clk_oe_n}, 16'h0000);
        check("frame driven", {15'h0000, synth_frame_oe_n}, 16'h0000);
    endtask

    task automatic t_fields();
        wr(OFF_SPAN, 8'hFE);
        rd_check("span field", OFF_SPAN, 8'h02);
        check("span port", {14'h0000, span_code}, 16'h0002);
        wr(OFF_MULT_LO, 8'hE8);
        wr(OFF_MULT_HI, 8'hFF);
        rd_check("mult high field", OFF_MULT_HI, 8'h3F);
        check("multiplier wide", {2'b00, multiplier}, 16'h3FE8);
        wr(OFF_MULT_HI, 8'h03);
        check("multiplier 1000", {2'b00, multiplier}, 16'd1000);
        wr(OFF_QUAD, 8'hFF);
        rd_check("quadrant field", OFF_QUAD, 8'h03);
        wr(OFF_QUAD, 8'h00);
        wr(OFF_FINE, 8'h80);
        check("fine port", {8'h00, fine_phase}, 16'h0080);
        for (int c = 0; c < 9; c++) begin
            wr(OFF_FP_RATE, 8'(c));
            rd_check("rate code", OFF_FP_RATE, 8'(c));
        end
        wr(8'h30, 8'h55);
        rd_check("unmapped write", 8'h30, 8'h00);
    endtask

    task automatic t_loop_select();
        set_pins('{holdover: 1'b1, lock: 1'b0, fail: 3'b000});
        rd_check("holdover flag", OFF_LOOP_FLAGS, 8'h01);
        set_pins('{holdover: 1'b0, lock: 1'b1, fail: 3'b000});
        rd_check("lock flag", OFF_LOOP_FLAGS, 8'h02);
        check("best ranked", {14'h0000, active_input}, 16'h0000);
        wr(OFF_ACTIVE_SEL, 8'h02);
        rd_check("select ignored in auto", OFF_ACTIVE_SEL, 8'h00);
        set_pins('{holdover: 1'b0, lock: 1'b1, fail: 3'b001});
        check("switch to second", {14'h0000, active_input}, 16'h0001);
        rd_check("select code 1", OFF_ACTIVE_SEL, 8'h01);
        rd_check("healthy selected", OFF_LOOP_FLAGS, 8'h02);
        wr(OFF_RANK01, 8'hF0);
        wr(OFF_RANK2, 8'h01);
        set_pins('{holdover: 1'b0, lock: 1'b1, fail: 3'b001});
        check("disabled skipped", {14'h0000, active_input}, 16'h0002);
        rd_check("select code 2", OFF_ACTIVE_SEL, 8'h02);
        wr(OFF_RANK01, 8'h11);
        wr(OFF_RANK2, 8'h01);
        set_pins('{holdover: 1'b0, lock: 1'b1, fail: 3'b000});
        check("tie lowest", {14'h0000, active_input}, 16'h0000);
        set_pins('{holdover: 1'b0, lock: 1'b1, fail: 3'b001});
        check("tie next", {14'h0000, active_input}, 16'h0001);
        set_pins('{holdover: 1'b1, lock: 1'b0, fail: 3'b111});
        check("none usable keeps", {14'h0000, active_input}, 16'h0001);
        rd_check("current fail flag", OFF_LOOP_FLAGS, 8'h05);
        set_pins('{holdover: 1'b0, lock: 1'b0, fail: 3'b000});
        wr(OFF_RANK01, 8'h10);
        wr(OFF_RANK2, 8'h32);
    endtask

    task automatic t_enables();
        wr(OFF_ENABLES, 8'h84);
        repeat (2) @(posedge sys_clk);
        #1;
        check("clock hiz", {14'h0000, synth_clk_oe_n, synth_frame_oe_n}, 16'h0002);
        wr(OFF_ENABLES, 8'h81);
        repeat (2) @(posedge sys_clk);
        #1;
        check("frame hiz", {14'h0000, synth_clk_oe_n, synth_frame_oe_n}, 16'h0001);
        wr(OFF_ENABLES, 8'h05);
        repeat (2) @(posedge sys_clk);
        #1;
        check("synth off", {14'h0000, synth_clk_oe_n, synth_frame_oe_n}, 16'h0003);
        wr(OFF_ENABLES, 8'h8F);
    endtask

    task automatic t_synth();
        int n;
        count_rises(1000, n);
        // 1000 x 8 kHz on a 200 MHz clock gives 40 rises per 1000 cycles, one either way
        check("clock rate", {15'h0000, n >= 39 && n <= 41}, 16'h0001);
        wr(OFF_GATING, 8'h0E);
        repeat (3) @(posedge sys_clk);
        count_rises(300, n);
        check("clock held", {15'h0000, synth_clk_out}, 16'h0000);
        check("clock stopped", 16'(n), 16'h0000);
        wr(OFF_GATING, 8'h0F);
        wr(OFF_FP_RATE, {4'h0, FP_64KHZ});
        wait_frame(30000, n);
        wait_frame(4000, n);
        check("frame period", 16'(n), 16'd3125);
        wr(OFF_GATING, 8'h0B);
        repeat (3) @(posedge sys_clk);
        n = 0;
        repeat (3500) begin
            @(posedge sys_clk);
            #1;
            if (synth_frame_out !== 1'b0) n++;
        end
        check("frame held low", 16'(n), 16'h0000);
    endtask

    // Manual mode: software picks the input, reserved codes are refused
    task automatic t_manual_select();
        wr(OFF_LOOP_MODE, 8'h00);
        wr(OFF_ACTIVE_SEL, 8'h02);
        rd_check("manual select", OFF_ACTIVE_SEL, 8'h02);
        set_pins('{holdover: 1'b0, lock: 1'b1, fail: 3'b100});
        rd_check("manual fail flag", OFF_LOOP_FLAGS, 8'h06);
        wr(OFF_ACTIVE_SEL, 8'h05);
        rd_check("reserved select refused", OFF_ACTIVE_SEL, 8'h02);
        wr(OFF_LOOP_MODE, 8'h03);
        set_pins('{holdover: 1'b0, lock: 1'b0, fail: 3'b000});
        check("auto back to best", {14'h0000, active_input}, 16'h0000);
        rd_check("auto flags clear", OFF_LOOP_FLAGS, 8'h00);
    endtask

    // With N at zero the phase stands still, so a half turn must invert the output
    task automatic t_quadrant();
        logic first;
        wr(OFF_MULT_LO, 8'h00);
        wr(OFF_MULT_HI, 8'h00);
        repeat (3) @(posedge sys_clk);
        #1;
        first = synth_clk_out;
        wr(OFF_QUAD, 8'h02);
        repeat (3) @(posedge sys_clk);
        #1;
        check("half turn inverts", {15'h0000, synth_clk_out}, {15'h0000, ~first});
        wr(OFF_QUAD, 8'h00);
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        t_reset_values();
        t_fields();
        t_loop_select();
        t_manual_select();
        t_enables();
        t_synth();
        t_quadrant();
        test_done();
    end
endmodule
`default_nettype wire
